//--- logic/adrc_consts.svh
// register map, field positions, reset values and counts of the converter control block
`ifndef ADRC_CONSTS_SVH
`define ADRC_CONSTS_SVH
`define AR_CTRL 8'h00
`define AR_PMSK 8'h04
`define AR_PREQ 8'h08
`define AR_QUE 8'h0C
`define AR_TRIG 8'h10
`define AR_INS 8'h14
`define AR_LIM 8'h18
`define AR_RCFG 8'h1C
`define AR_EVT 8'h20
`define AR_DIN 8'h24
`define AR_RES0 3'h2
`define AR_RES1 3'h3
`define AR_B_EN 0
`define AR_B_M8 1
`define AR_B_SYNC 2
`define AR_B_APD 3
`define AR_B_EXM 4
`define AR_B_MT 5
`define AR_B_BW 6
`define AR_B_CHN 7
`define AR_B_SCH 24
`define AR_B_LF 25
`define AR_B_QGO 8
`define AR_F_SMP 15:8
`define AR_F_CNV 23:16
`define AR_F_ACC 27:26
`define AR_F_PTR 3:0
`define AR_F_QTR 7:4
`define AR_F_PI 9:8
`define AR_F_PP 11:10
`define AR_F_PQ 13:12
`define AR_F_LO 9:0
`define AR_F_HI 25:16
`define AR_F_WFR 7:0
`define AR_F_MSK 11:8
`define AR_F_CH 3:0
`define AR_F_EXT 6:4
`define AR_CTRL_RST 32'h0004_0400
`define AR_LIM_RST 32'h03FF_0000
`define AR_TRIG_RST 32'h0000_0300
`define AR_CTRL_MSK 32'h0FFF_FFFF
`define AR_TRIG_MSK 32'h0000_3FFF
`define AR_LIM_MSK 32'h03FF_03FF
`define AR_RCFG_MSK 32'h0000_0FFF
`define AR_CH_MSK 32'h0000_01FF
`define AR_SCH0 4'h7
`define AR_SCH1 4'h8
`define AR_MSB 4'h9
`define AR_LSB8 4'h2
`define AR_LSB10 4'h0
`define AR_TOP 10'h200
`define AR_QFULL 3'h4
`define AR_BFULL 4'h8
`endif

//--- logic/adrc_pkg.sv
// types shared by the converter control block
`default_nettype none
package adrc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SMP, ST_CNV, ST_ACC, ST_WR} adrc_state_e;
  typedef logic [11:0] adrc_res_t;
  typedef logic [6:0] adrc_qent_t;
  typedef logic [9:0] adrc_code_t;
endpackage : adrc_pkg
`default_nettype wire

//--- logic/adrc_top.sv
// request sequencing, dual SAR control and result handling of the converter pair
// Overview of operation
// - results are 10-bit; a mode bit gives shorter 8-bit conversions
// - nine channels; channels 7 and 8 reach both converters
// - sample and conversion phase lengths come from software
// - sync mode makes the second converter sample together with the first
// - parallel source pends many channels, served lowest channel first
// - queued source serves channels in the order software wrote them
// - an inserted channel runs between steps, sequence left untouched
// - among pending sources the highest priority level wins
// - sources start by selected trigger inputs or by software
// - limit checking and accumulation cut down result reads
// - eight result registers per converter, chainable into a FIFO
// - wait-for-read is enabled per result register
// - external multiplexer select follows each queued conversion
// - auto power-down whenever no conversion runs
// - broken-wire precharge and multiplexer test are provided
// - each stored result pulses an event for the transfer unit
// - digital input stage of each analog pin can be disabled
// - selectable interrupt request from result and limit events
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "adrc_consts.svh"
module adrc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic [3:0] trigIn,
  input wire logic [1:0] cmpHigh,
  output wire adrc_pkg::adrc_code_t dacCode0,
  output wire adrc_pkg::adrc_code_t dacCode1,
  output var logic [1:0] sampleEn,
  output var logic [3:0] chanSel0,
  output var logic [3:0] chanSel1,
  output var logic [2:0] extMuxSel,
  output var logic pwrDown,
  output var logic bwPrecharge,
  output wire logic muxTest,
  output wire logic [8:0] digInDisable,
  output var logic [1:0] resultEvt,
  output var logic limitEvt,
  output var logic irqReq
);
  import adrc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [31:0] ctrl, pmsk, trig, lim, rcfg, din, rdMux;
  logic [31:0] next_ctrl, next_pmsk, next_trig, next_lim, next_rcfg, next_din, next_prdata;
  logic next_pready, next_pslverr, acc, wr, rd, mapped, sync, m8, grant;
  logic qPush, qGo, insSet, qV, selIns, selPar, selQ;
  logic [1:0] pI, pP, pQ;
  logic [3:0] evtClr, lowBit, schCh, parCh, winCh;
  logic [8:0] parSet;
  logic [2:0] winExt;
  wire [31:0] rdW [2];
  wire [11:0] accW [2];
  wire [9:0] dacW [2];
  wire [1:0] blk, limOut;
  adrc_state_e st, next_st;
  logic [7:0] tmr, next_tmr;
  logic [3:0] bitIdx, next_bitIdx, curCh, next_curCh, insCh, next_insCh, evt, next_evt;
  logic [2:0] curExt, next_curExt, qCnt, next_qCnt;
  logic [1:0] accCnt, next_accCnt, qWp, next_qWp, qRp, next_qRp, stEn;
  logic [8:0] parPend, next_parPend;
  logic insPend, next_insPend, qRun, next_qRun, sarStart, bitEnd, accEn;
  adrc_qent_t qEnt [4];
  adrc_qent_t next_qEnt [4];
  adrc_qent_t qHead;
  logic [1:0] next_sampleEn, next_resultEvt;
  logic [3:0] next_chanSel0;
  logic [2:0] next_extMuxSel;
  logic next_pwrDown, next_bwPrecharge, next_limitEvt, next_irqReq;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign sync = ctrl[`AR_B_SYNC];
  assign m8 = ctrl[`AR_B_M8];
  assign lowBit = m8 ? `AR_LSB8 : `AR_LSB10;
  assign schCh = ctrl[`AR_B_SCH] ? `AR_SCH1 : `AR_SCH0;
  assign pI = trig[`AR_F_PI];
  assign pP = trig[`AR_F_PP];
  assign pQ = trig[`AR_F_PQ];
  assign qHead = qEnt[qRp];
  assign dacCode0 = dacW[0];
  assign dacCode1 = dacW[1];
  assign muxTest = ctrl[`AR_B_MT];
  assign digInDisable = din[8:0];
  assign evtClr = (wr && paddr == `AR_EVT) ? pwdata[3:0] : 4'h0;
  assign insSet = wr && paddr == `AR_INS;
  assign qPush = wr && paddr == `AR_QUE && pwdata[`AR_F_CH] <= `AR_SCH1;
  assign qGo = (wr && paddr == `AR_QUE && pwdata[`AR_B_QGO]) || |(trigIn & trig[`AR_F_QTR]);

  always_comb begin
    parSet = (wr && paddr == `AR_PREQ) ? pwdata[8:0] : 9'h000;
    if (|(trigIn & trig[`AR_F_PTR])) begin
      parSet = parSet | pmsk[8:0];
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      `AR_CTRL: rdMux = ctrl;
      `AR_PMSK: rdMux = pmsk;
      `AR_PREQ: rdMux = {23'h000000, parPend};
      `AR_QUE: rdMux = {23'h000000, qRun, 5'h00, qCnt};
      `AR_TRIG: rdMux = trig;
      `AR_INS: rdMux = {27'h0000000, insPend, insCh};
      `AR_LIM: rdMux = lim;
      `AR_RCFG: rdMux = rcfg;
      `AR_EVT: rdMux = {28'h0000000, evt};
      `AR_DIN: rdMux = din;
      default: begin
        if (paddr[7:5] == `AR_RES0) rdMux = rdW[0];
        else if (paddr[7:5] == `AR_RES1) rdMux = rdW[1];
        else mapped = 1'b0;
      end
    endcase
  end

  // zero-wait slave: data latched in setup, so reads never see a half-updated word
  always_comb begin
    next_ctrl = ctrl;
    next_pmsk = pmsk;
    next_trig = trig;
    next_lim = lim;
    next_rcfg = rcfg;
    next_din = din;
    next_pready = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata = (psel & ~penable & ~pwrite) ? rdMux : prdata;
    if (wr) begin
      case (paddr)
        `AR_CTRL: next_ctrl = pwdata & `AR_CTRL_MSK;
        `AR_PMSK: next_pmsk = pwdata & `AR_CH_MSK;
        `AR_TRIG: next_trig = pwdata & `AR_TRIG_MSK;
        `AR_LIM: next_lim = pwdata & `AR_LIM_MSK;
        `AR_RCFG: next_rcfg = pwdata & `AR_RCFG_MSK;
        `AR_DIN: next_din = pwdata & `AR_CH_MSK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= `AR_CTRL_RST;
      pmsk <= 32'h0000_0000;
      trig <= `AR_TRIG_RST;
      lim <= `AR_LIM_RST;
      rcfg <= 32'h0000_0000;
      din <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      pmsk <= next_pmsk;
      trig <= next_trig;
      lim <= next_lim;
      rcfg <= next_rcfg;
      din <= next_din;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  always_comb begin
    parCh = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (parPend[i]) parCh = 4'(i);
    end
    qV = qRun && qCnt != 3'h0;
    selIns = insPend && (parPend == 9'h000 || pI >= pP) && (!qV || pI >= pQ);
    selPar = !selIns && parPend != 9'h000 && (!qV || pP >= pQ);
    selQ = !selIns && !selPar && qV;
    winCh = selIns ? insCh : (selPar ? parCh : qHead[`AR_F_CH]);
    winExt = selQ ? qHead[`AR_F_EXT] : 3'h0;
    grant = st == ST_IDLE && ctrl[`AR_B_EN] && (selIns || selPar || selQ) && blk == 2'b00;
  end

  always_comb begin
    next_st = st;
    next_tmr = tmr;
    next_bitIdx = bitIdx;
    next_curCh = curCh;
    next_curExt = curExt;
    next_accCnt = accCnt;
    next_qEnt = qEnt;
    next_qWp = qWp;
    next_qRp = qRp;
    next_qCnt = qCnt;
    next_qRun = qGo ? 1'b1 : qRun;
    sarStart = 1'b0;
    bitEnd = 1'b0;
    accEn = 1'b0;
    stEn = 2'b00;
    next_resultEvt = 2'b00;
    next_limitEvt = 1'b0;
    next_evt = evt & ~evtClr;
    next_parPend = (parPend & ~((grant && selPar) ? 9'h001 << parCh : 9'h000)) | parSet;
    next_insPend = insSet || (insPend && !(grant && selIns));
    next_insCh = insSet ? pwdata[`AR_F_CH] : insCh;
    if (qPush && (qCnt != `AR_QFULL || (grant && selQ))) begin
      next_qEnt[qWp] = pwdata[6:0];
      next_qWp = qWp + 2'h1;
      next_qCnt = next_qCnt + 3'h1;
    end
    if (grant && selQ) begin
      next_qRp = qRp + 2'h1;
      next_qCnt = next_qCnt - 3'h1;
      if (next_qCnt == 3'h0 && !qGo) next_qRun = 1'b0;
    end
    case (st)
      ST_IDLE: begin
        if (grant) begin
          next_st = ST_SMP;
          next_tmr = ctrl[`AR_F_SMP];
          next_curCh = winCh;
          next_curExt = winExt;
          next_accCnt = 2'h0;
        end
      end
      ST_SMP: begin
        if (tmr == 8'h00) begin
          next_st = ST_CNV;
          next_tmr = ctrl[`AR_F_CNV];
          next_bitIdx = `AR_MSB;
          sarStart = 1'b1;
        end else next_tmr = tmr - 8'h01;
      end
      ST_CNV: begin
        if (tmr == 8'h00) begin
          bitEnd = 1'b1;
          next_tmr = ctrl[`AR_F_CNV];
          if (bitIdx == lowBit) next_st = ST_ACC;
          else next_bitIdx = bitIdx - 4'h1;
        end else next_tmr = tmr - 8'h01;
      end
      ST_ACC: begin
        accEn = 1'b1;
        if (accCnt == ctrl[`AR_F_ACC]) next_st = ST_WR;
        else begin
          next_accCnt = accCnt + 2'h1;
          next_st = ST_SMP;
          next_tmr = ctrl[`AR_F_SMP];
        end
      end
      ST_WR: begin
        next_st = ST_IDLE;
        for (int c = 0; c < 2; c++) begin
          if (c == 0 || sync) begin
            stEn[c] = !(ctrl[`AR_B_LF] && !limOut[c]);
            next_resultEvt[c] = stEn[c];
            next_evt[c] = next_evt[c] | stEn[c];
            next_limitEvt = next_limitEvt | limOut[c];
            next_evt[2] = next_evt[2] | limOut[c];
            next_evt[3] = next_evt[3] | (ctrl[`AR_B_BW] && accW[c] == 12'h000);
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
    next_sampleEn = {next_st == ST_SMP && sync, next_st == ST_SMP};
    next_chanSel0 = next_curCh;
    next_extMuxSel = ctrl[`AR_B_EXM] ? next_curExt : 3'h0;
    next_pwrDown = (ctrl[`AR_B_APD] || !ctrl[`AR_B_EN]) && next_st == ST_IDLE;
    next_bwPrecharge = ctrl[`AR_B_BW] && next_st == ST_SMP && st != ST_SMP;
    next_irqReq = |(next_evt & rcfg[`AR_F_MSK]);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= ST_IDLE;
      tmr <= 8'h00;
      bitIdx <= 4'h0;
      curCh <= 4'h0;
      curExt <= 3'h0;
      accCnt <= 2'h0;
      parPend <= 9'h000;
      insPend <= 1'b0;
      insCh <= 4'h0;
      for (int i = 0; i < 4; i++) qEnt[i] <= 7'h00;
      qWp <= 2'h0;
      qRp <= 2'h0;
      qCnt <= 3'h0;
      qRun <= 1'b0;
      evt <= 4'h0;
      sampleEn <= 2'b00;
      chanSel0 <= 4'h0;
      chanSel1 <= 4'h0;
      extMuxSel <= 3'h0;
      pwrDown <= 1'b1;
      bwPrecharge <= 1'b0;
      resultEvt <= 2'b00;
      limitEvt <= 1'b0;
      irqReq <= 1'b0;
    end else begin
      st <= next_st;
      tmr <= next_tmr;
      bitIdx <= next_bitIdx;
      curCh <= next_curCh;
      curExt <= next_curExt;
      accCnt <= next_accCnt;
      parPend <= next_parPend;
      insPend <= next_insPend;
      insCh <= next_insCh;
      qEnt <= next_qEnt;
      qWp <= next_qWp;
      qRp <= next_qRp;
      qCnt <= next_qCnt;
      qRun <= next_qRun;
      evt <= next_evt;
      sampleEn <= next_sampleEn;
      chanSel0 <= next_chanSel0;
      chanSel1 <= schCh;
      extMuxSel <= next_extMuxSel;
      pwrDown <= next_pwrDown;
      bwPrecharge <= next_bwPrecharge;
      resultEvt <= next_resultEvt;
      limitEvt <= next_limitEvt;
      irqReq <= next_irqReq;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_cv
    adrc_res_t resD [8];
    adrc_res_t next_resD [8];
    logic [3:0] resC [8];
    logic [3:0] next_resC [8];
    logic [7:0] resV, next_resV;
    logic [2:0] wp, rp, next_wp, next_rp, ri, ta, ts;
    logic [3:0] cnt, next_cnt, chS;
    adrc_code_t sar, next_sar;
    adrc_res_t accR, next_accR;
    logic pop, chain, popC, pushC;
    assign chain = ctrl[`AR_B_CHN];
    assign chS = (c == 0) ? curCh : schCh;
    assign ta = (c == 0) ? winCh[2:0] : schCh[2:0];
    assign ts = chain ? wp : chS[2:0];
    assign pop = rd && paddr[7:5] == ((c == 0) ? `AR_RES0 : `AR_RES1);
    // chained reads return the oldest entry
    assign ri = chain ? rp : paddr[4:2];
    assign rdW[c] = {chain ? cnt != 4'h0 : resV[ri], 11'h000, resC[ri], 4'h0, resD[ri]};
    assign blk[c] = (c == 0 || sync) && rcfg[`AR_F_WFR] != 8'h00 &&
      (chain ? cnt == `AR_BFULL && rcfg[wp] : resV[ta] && rcfg[ta]);
    assign accW[c] = accR;
    assign dacW[c] = sar;
    assign limOut[c] = accR < {2'h0, lim[`AR_F_LO]} || accR > {2'h0, lim[`AR_F_HI]};
    assign popC = pop && chain && cnt != 4'h0;
    assign pushC = stEn[c] && chain;

    always_comb begin
      next_resD = resD;
      next_resC = resC;
      next_resV = resV;
      next_wp = wp;
      next_rp = rp;
      next_cnt = cnt;
      next_sar = sar;
      next_accR = accR;
      if (sarStart) next_sar = `AR_TOP;
      else if (bitEnd) begin
        next_sar[bitIdx] = cmpHigh[c];
        if (bitIdx != lowBit) next_sar[bitIdx - 4'h1] = 1'b1;
      end
      if (accEn) begin
        next_accR = (accCnt == 2'h0 ? 12'h000 : accR) + (m8 ? {4'h0, sar[9:2]} : {2'h0, sar});
      end
      if (pop && !chain) next_resV[paddr[4:2]] = 1'b0;
      if (stEn[c]) begin
        next_resD[ts] = accR;
        next_resC[ts] = chS;
        next_resV[ts] = 1'b1;
      end
      if (popC) next_rp = rp + 3'h1;
      if (pushC) next_wp = wp + 3'h1;
      // full chain without wait-for-read drops its oldest entry
      if (pushC && !popC && cnt == `AR_BFULL) next_rp = rp + 3'h1;
      else if (pushC && !popC) next_cnt = cnt + 4'h1;
      else if (popC && !pushC) next_cnt = cnt - 4'h1;
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        for (int i = 0; i < 8; i++) begin
          resD[i] <= 12'h000;
          resC[i] <= 4'h0;
        end
        resV <= 8'h00;
        wp <= 3'h0;
        rp <= 3'h0;
        cnt <= 4'h0;
        sar <= 10'h000;
        accR <= 12'h000;
      end else begin
        resD <= next_resD;
        resC <= next_resC;
        resV <= next_resV;
        wp <= next_wp;
        rp <= next_rp;
        cnt <= next_cnt;
        sar <= next_sar;
        accR <= next_accR;
      end
    end
  end

  bits8_mode_a: assert property ((st == ST_CNV && tmr == 8'h00 && m8 && bitIdx == `AR_LSB8) |=> st == ST_ACC)
    else $error("8-bit mode did not end after bit 2");
  // reset leaves chanSel1 at zero for the first cycle after release
  shared_chan_a: assert property ($past(rst) || chanSel1 == `AR_SCH0 || chanSel1 == `AR_SCH1)
    else $error("second converter off the shared channels");
  sample_len_a: assert property ((st == ST_SMP && tmr != 8'h00) |=> st == ST_SMP && tmr == $past(tmr) - 8'h01)
    else $error("sample phase cut short");
  sync_sample_a: assert property (sampleEn[1] |-> sampleEn[0] && sync)
    else $error("second converter sampled alone");
  par_order_a: assert property ((grant && selPar) |-> (parPend & ((9'h001 << winCh) - 9'h001)) == 9'h000)
    else $error("parallel source skipped a lower channel");
  queue_order_a: assert property ((grant && selQ) |=> curCh == $past(qHead[3:0]) && st == ST_SMP)
    else $error("queue head not served");
  insert_keep_a: assert property ((grant && selIns) |=> (parPend & $past(parPend)) == $past(parPend))
    else $error("insert disturbed parallel sequence");
  prio_win_a: assert property ((grant && selQ) |-> !(insPend && pI >= pQ) && !(parPend != 9'h000 && pP >= pQ))
    else $error("lower priority source granted");
  apd_idle_a: assert property (pwrDown |-> st == ST_IDLE)
    else $error("powered down during conversion");
  wfr_hold_a: assert property ((st == ST_IDLE && blk != 2'b00) |=> st == ST_IDLE)
    else $error("conversion started over unread result");
  pend_keep_a: assert property ((insPend && !(grant && selIns)) |=> insPend)
    else $error("losing insert request dropped");
  limit_evt_a: assert property ((st == ST_WR && limOut[0]) |=> limitEvt && evt[2])
    else $error("limit violation not flagged");
  cover_insert_c: cover property (grant && selIns && parPend != 9'h000);
  cover_accum_c: cover property (st == ST_ACC && accCnt != 2'h0);
  cover_chain_full_c: cover property (g_cv[0].cnt == `AR_BFULL && ctrl[`AR_B_CHN]);
  cover_blocked_c: cover property (st == ST_IDLE && blk != 2'b00 && ctrl[`AR_B_EN]);
endmodule : adrc_top
`default_nettype wire

//--- test/adc_request_result_control_tb.sv
// self-checking bench: register tasks and conversion scenarios
`timescale 1ns/10ps
`default_nettype none
module adc_request_result_control_tb;
  import adrc_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, se;
  logic pwrDown, bwPrecharge, muxTest, limitEvt, irqReq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] trigIn, chanSel0, chanSel1;
  logic [1:0] cmpHigh, sampleEn, resultEvt;
  logic [2:0] extMuxSel;
  logic [8:0] digInDisable;
  adrc_code_t dacCode0, dacCode1;
  logic [3:0] ord[$];
  int err_total, num_checks, cyc, ev1, nbw, nlim;
  adrc_top i_adrc_top (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigIn(trigIn), .cmpHigh(cmpHigh), .dacCode0(dacCode0), .dacCode1(dacCode1),
    .sampleEn(sampleEn), .chanSel0(chanSel0), .chanSel1(chanSel1), .extMuxSel(extMuxSel),
    .pwrDown(pwrDown), .bwPrecharge(bwPrecharge), .muxTest(muxTest),
    .digInDisable(digInDisable), .resultEvt(resultEvt), .limitEvt(limitEvt), .irqReq(irqReq));
  adrc_analog_model i_adrc_analog_model (.mclk(mclk), .sampleEn(sampleEn), .chanSel0(chanSel0),
    .chanSel1(chanSel1), .extMuxSel(extMuxSel), .dacCode0(dacCode0), .dacCode1(dacCode1),
    .cmpHigh(cmpHigh));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // the order log is the bench's view of which channel each result stored by the first converter came from
  always @(posedge mclk) begin
    cyc++;
    if (bwPrecharge === 1'b1) nbw++;
    if (limitEvt === 1'b1) nlim++;
    if (resultEvt[0] === 1'b1) ord.push_back(chanSel0);
    if (resultEvt[1] === 1'b1) ev1++;
    if (cyc == 30000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic go(input logic [8:0] m, input int n);
    ord.delete();
    apb(1'b1, 8'h08, {23'h0, m});
    wait (ord.size() >= n);
    @(posedge mclk);
  endtask : go
  function automatic logic [9:0] lv(input logic [3:0] ch, input logic [2:0] e);
    return 10'(ch * 97 + e * 5 + 20);
  endfunction : lv
  function automatic logic [31:0] rw(input logic [3:0] ch, input logic [9:0] d);
    return {1'b1, 11'h0, ch, 6'h0, d};
  endfunction : rw
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trigIn = 4'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0004_0400, "ctrl reset");
    chk(se, 0, "mapped read");
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0000_0300, "trig reset");
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h03FF_0000, "lim reset");
    chk(pwrDown, 1, "idle power");
    apb(1'b0, 8'h34, 32'h0);
    chk(se, 1, "unmapped");
    $display("test reset done");
    apb(1'b1, 8'h00, 32'h0000_0181);
    go(9'h084, 2);
    apb(1'b0, 8'h58, 32'h0);
    chk(q, rw(2, lv(2, 0)), "fifo first");
    apb(1'b0, 8'h44, 32'h0);
    chk(q, rw(7, lv(7, 0)), "fifo second");
    apb(1'b0, 8'h40, 32'h0);
    chk(q[31], 0, "fifo empty");
    $display("test chain done");
    apb(1'b1, 8'h00, 32'h0000_0109);
    go(9'h00A, 2);
    chk(ord[0], 1, "par first");
    chk(ord[1], 3, "par second");
    apb(1'b0, 8'h4C, 32'h0);
    chk(q, rw(3, lv(3, 0)), "result 3");
    apb(1'b0, 8'h4C, 32'h0);
    chk(q[31], 0, "valid cleared");
    chk(pwrDown, 1, "auto power down");
    $display("test parallel done");
    apb(1'b1, 8'h1C, 32'h0000_0402);
    ord.delete();
    apb(1'b1, 8'h08, 32'h0000_0002);
    repeat (40) @(posedge mclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(q[1], 1, "still pending");
    chk(ord.size(), 0, "held back");
    apb(1'b0, 8'h44, 32'h0);
    chk(q, rw(1, lv(1, 0)), "old kept");
    wait (ord.size() >= 1);
    chk(ord[0], 1, "released");
    $display("test wait-for-read done");
    apb(1'b1, 8'h18, 32'h0050_0000);
    go(9'h040, 1);
    apb(1'b0, 8'h20, 32'h0);
    chk(q[2], 1, "limit flag");
    chk(irqReq, 1, "irq set");
    apb(1'b1, 8'h20, 32'h0000_0004);
    @(posedge mclk);
    chk(irqReq, 0, "irq cleared");
    $display("test limit done");
    apb(1'b1, 8'h00, 32'h0000_0119);
    ord.delete();
    apb(1'b1, 8'h0C, 32'h0000_0025);
    apb(1'b1, 8'h0C, 32'h0000_0002);
    apb(1'b1, 8'h0C, 32'h0000_0106);
    apb(1'b1, 8'h14, 32'h0000_0000);
    wait (ord.size() >= 4);
    chk(ord[0], 5, "queue first");
    chk(ord[1], 0, "inserted");
    chk(ord[2], 2, "queue resumes");
    chk(ord[3], 6, "queue last");
    apb(1'b0, 8'h54, 32'h0);
    chk(q, rw(5, lv(5, 2)), "ext mux");
    $display("test queue done");
    apb(1'b1, 8'h00, 32'h0000_010B);
    go(9'h010, 1);
    apb(1'b0, 8'h50, 32'h0);
    chk(q, rw(4, lv(4, 0) >> 2), "8-bit");
    $display("test short mode done");
    apb(1'b1, 8'h00, 32'h0100_0105);
    ev1 = 0;
    go(9'h004, 1);
    chk(ev1, 1, "sync result");
    apb(1'b0, 8'h60, 32'h0);
    chk(q, rw(8, lv(8, 0)), "shared channel");
    $display("test sync done");
    apb(1'b1, 8'h04, 32'h0000_0008);
    apb(1'b1, 8'h10, 32'h0000_0301);
    apb(1'b1, 8'h00, 32'h0400_0141);
    ord.delete();
    nbw = 0;
    nlim = 0;
    trigIn <= 4'h1;
    @(posedge mclk);
    trigIn <= 4'h0;
    wait (ord.size() >= 1);
    @(posedge mclk);
    chk(ord[0], 3, "trigger start");
    chk(nbw, 2, "precharge per sample");
    chk(nlim, 1, "limit pulse");
    apb(1'b0, 8'h4C, 32'h0);
    chk(q, rw(3, lv(3, 0) * 2), "accumulated");
    $display("test trigger done");
    apb(1'b1, 8'h24, 32'h0000_01A5);
    chk(digInDisable, 32'h1A5, "digital disable");
    apb(1'b1, 8'h00, 32'h0000_0020);
    chk(muxTest, 1, "mux test");
    $display("test pins done");
    report_and_stop();
  end
endmodule : adc_request_result_control_tb
`default_nettype wire

//--- test/adrc_analog_model.sv
// analog source model: channel levels, sample-and-hold and comparator per converter
`timescale 1ns/10ps
`default_nettype none
module adrc_analog_model (
  input wire logic mclk,
  input wire logic [1:0] sampleEn,
  input wire logic [3:0] chanSel0,
  input wire logic [3:0] chanSel1,
  input wire logic [2:0] extMuxSel,
  input wire adrc_pkg::adrc_code_t dacCode0,
  input wire adrc_pkg::adrc_code_t dacCode1,
  output var logic [1:0] cmpHigh
);
  import adrc_pkg::*;
  adrc_code_t held0;
  adrc_code_t held1;
  function automatic adrc_code_t level(input logic [3:0] ch, input logic [2:0] ext);
    return 10'(ch * 97 + ext * 5 + 20);
  endfunction : level
  // the held sample stays put while the bits are decided, as on a real hold capacitor
  always_ff @(posedge mclk) begin
    if (sampleEn[0]) begin
      held0 <= level(chanSel0, extMuxSel);
    end
    if (sampleEn[1]) begin
      held1 <= level(chanSel1, 3'h0);
    end
  end
  always_comb begin
    cmpHigh = {held1 >= dacCode1, held0 >= dacCode0};
  end
endmodule : adrc_analog_model
`default_nettype wire
